// File: hw/pci_interp.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
// Function
// - frame: address, instruction, type, motor/bank, four value bytes msb first, checksum
// - move type 01 adds a signed offset to the current position
// - move type 02 moves to the stored coordinate numbered by the value
// - instruction 5 writes the value into the axis parameter named by type
// - axis parameter writes stay in volatile storage, never saved
// - instruction 6 returns the selected axis parameter in the reply value
// - reads also load the accumulator in standalone mode only
// - instruction 9 writes a global parameter; banks 0, 2, 3 only
// - bank 0 module settings, bank 2 user variables, bank 3 interrupt setup
// - bank 0 writes also raise a non-volatile save
// - instruction 10 ignores the value and returns the global parameter
// - bank 0 parameter 66 holds the serial address, read and write
// - axis parameter 1 reads the actual position
// - axis parameter 4 sets the maximum positioning speed
// - move instruction 4 type 0 takes an absolute signed 32-bit target
module pci_interp (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // host frame bytes
  input  wire logic                 rx_valid,
  input  wire logic                 rx_sof,
  input  wire logic [7:0]           rx_byte,
  output logic                      reply_valid,
  output pci_pkg::pci_reply_type    reply,
  // motion side
  input  wire logic [31:0]          act_pos,
  output logic                      move_start,
  output logic [31:0]               move_target,
  output logic [31:0]               max_speed,
  output logic                      nv_save,
  output logic [9:0]                nv_index,
  output logic [31:0]               nv_value,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata
);
  pci_pkg::pci_state_type state_reg;
  pci_pkg::pci_frame_type rx_frame;
  pci_pkg::pci_frame_type f_reg;
  logic        rx_fv;
  logic        rx_err;
  logic [7:0]  ser_addr_reg;
  logic        standalone_reg;
  logic [31:0] accu_reg;
  logic [7:0]  last_status_reg;
  logic [4:0]  point_idx_reg;
  logic [31:0] axis_rd;
  logic [31:0] glob_rd;
  logic [31:0] point_rd;
  logic        exec;
  logic        is_move;
  logic        is_axw;
  logic        is_axr;
  logic        is_glw;
  logic        is_glr;
  logic        bank_ok;
  logic        ok;
  logic        axis_wr;
  logic        glob_wr;
  logic [7:0]  status;
  logic [31:0] rd_val;

  pci_frame_rx u_rx (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .rx_valid    (rx_valid),
    .rx_sof      (rx_sof),
    .rx_byte     (rx_byte),
    .own_addr    (ser_addr_reg),
    .frame       (rx_frame),
    .frame_valid (rx_fv),
    .cksum_err   (rx_err)
  );

  // axis parameters: plain volatile storage, nothing ever copies it out
  pci_mem #(.W(32), .D(256), .AW(8)) u_axis (
    .clk     (mclk),
    .wr_en   (axis_wr),
    .wr_addr (f_reg.ptype),
    .wr_data (f_reg.value),
    .rd_addr (rx_frame.ptype),
    .rd_data (axis_rd)
  );

  // global parameters, indexed by bank and number
  pci_mem #(.W(32), .D(1024), .AW(10)) u_glob (
    .clk     (mclk),
    .wr_en   (glob_wr),
    .wr_addr ({f_reg.bank[1:0], f_reg.ptype}),
    .wr_data (f_reg.value),
    .rd_addr ({rx_frame.bank[1:0], rx_frame.ptype}),
    .rd_data (glob_rd)
  );

  // stored coordinates, loaded by software through the register port
  pci_mem #(.W(32), .D(32), .AW(5)) u_point (
    .clk     (mclk),
    .wr_en   (reg_wr && reg_addr == pci_pkg::REG_POINT_DATA),
    .wr_addr (point_idx_reg),
    .wr_data (reg_wdata),
    .rd_addr (rx_frame.value[4:0]),
    .rd_data (point_rd)
  );

  // memories read in the idle cycle, so the frame executes one cycle later
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= pci_pkg::PCI_IDLE;
      f_reg     <= '0;
    end else begin
      case (state_reg)
        pci_pkg::PCI_IDLE: begin
          if (rx_fv) begin
            state_reg <= pci_pkg::PCI_EXEC;
            f_reg     <= rx_frame;
          end
        end
        pci_pkg::PCI_EXEC: begin
          state_reg <= pci_pkg::PCI_IDLE;
        end
        default: begin
          state_reg <= pci_pkg::PCI_IDLE;
        end
      endcase
    end
  end

  // instruction decode of the held frame
  assign exec    = (state_reg == pci_pkg::PCI_EXEC);
  assign is_move = (f_reg.instr == pci_pkg::MOVE_TO_POSITION_CMD);
  assign is_axw  = (f_reg.instr == pci_pkg::AXIS_PARAM_WRITE_CMD);
  assign is_axr  = (f_reg.instr == pci_pkg::AXIS_PARAM_READ_CMD);
  assign is_glw  = (f_reg.instr == pci_pkg::GLOBAL_PARAM_WRITE_CMD);
  assign is_glr  = (f_reg.instr == pci_pkg::GLOBAL_PARAM_READ_CMD);
  assign bank_ok = (f_reg.bank == pci_pkg::BANK_MODULE) ||
                   (f_reg.bank == pci_pkg::BANK_USER) ||
                   (f_reg.bank == pci_pkg::BANK_IRQ_CFG);

  // reply status; checks on bank, type and coordinate number
  always_comb begin
    status = pci_pkg::ST_OK;
    if (!(is_move || is_axw || is_axr || is_glw || is_glr)) begin
      status = pci_pkg::ST_BAD_CMD;
    end else if ((is_glw || is_glr) && !bank_ok) begin
      status = pci_pkg::ST_BAD_VALUE;
    end else if (is_move && f_reg.ptype > pci_pkg::STORED_COORDINATE_MOVE_TYPE) begin
      status = pci_pkg::ST_BAD_TYPE;
    end else if (is_move && f_reg.ptype == pci_pkg::STORED_COORDINATE_MOVE_TYPE &&
                 f_reg.value > pci_pkg::MAX_POINT_NUM) begin
      status = pci_pkg::ST_BAD_VALUE;
    end
  end

  assign ok      = exec && (status == pci_pkg::ST_OK);
  assign axis_wr = ok && is_axw;
  assign glob_wr = ok && is_glw;

  // value returned by the two read commands; request value unused
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_axr) begin
      if (f_reg.ptype == pci_pkg::AXIS_ACT_POS) begin
        rd_val = act_pos;
      end else if (f_reg.ptype == pci_pkg::AXIS_MAX_SPEED) begin
        rd_val = max_speed;
      end else begin
        rd_val = axis_rd;
      end
    end else if (is_glr) begin
      if (f_reg.bank == pci_pkg::BANK_MODULE && f_reg.ptype == pci_pkg::GLOB_SER_ADDR) begin
        rd_val = {24'h00_0000, ser_addr_reg};
      end else begin
        rd_val = glob_rd;
      end
    end
  end

  // reply: one cycle pulse, value zero unless a read succeeded
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reply_valid <= 1'b0;
      reply       <= '0;
    end else if (exec) begin
      reply_valid  <= 1'b1;
      reply.status <= status;
      reply.instr  <= f_reg.instr;
      reply.value  <= ok ? rd_val : 32'h0000_0000;
    end else if (rx_err) begin
      reply_valid  <= 1'b1;
      reply.status <= pci_pkg::ST_CKSUM;
      reply.instr  <= rx_frame.instr;
      reply.value  <= 32'h0000_0000;
    end else begin
      reply_valid <= 1'b0;
    end
  end

  // move target: absolute, relative signed offset, or stored coordinate
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      move_start  <= 1'b0;
      move_target <= 32'h0000_0000;
    end else begin
      move_start <= ok && is_move;
      if (ok && is_move) begin
        case (f_reg.ptype)
          pci_pkg::ABSOLUTE_MOVE_TYPE: move_target <= f_reg.value;
          pci_pkg::RELATIVE_MOVE_TYPE: move_target <= act_pos + f_reg.value;
          default:                     move_target <= point_rd;
        endcase
      end
    end
  end

  // speed limit handed to the motion side with every move
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      max_speed <= pci_pkg::MAX_SPEED_RST;
    end else if (axis_wr && f_reg.ptype == pci_pkg::AXIS_MAX_SPEED) begin
      max_speed <= f_reg.value;
    end
  end

  // serial address also gates which frames the receiver accepts
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ser_addr_reg <= pci_pkg::SER_ADDR_RST;
    end else if (glob_wr && f_reg.bank == pci_pkg::BANK_MODULE &&
                 f_reg.ptype == pci_pkg::GLOB_SER_ADDR) begin
      ser_addr_reg <= f_reg.value[7:0];
    end
  end

  // bank 0 writes are pushed to the non-volatile store without a save command
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nv_save  <= 1'b0;
      nv_index <= 10'h000;
      nv_value <= 32'h0000_0000;
    end else begin
      nv_save <= glob_wr && f_reg.bank == pci_pkg::BANK_MODULE;
      if (glob_wr) begin
        nv_index <= {f_reg.bank[1:0], f_reg.ptype};
        nv_value <= f_reg.value;
      end
    end
  end

  // accumulator follows reads only in standalone mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      accu_reg <= 32'h0000_0000;
    end else if (ok && (is_axr || is_glr) && standalone_reg) begin
      accu_reg <= rd_val;
    end
  end

  // last status for software
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      last_status_reg <= 8'h00;
    end else if (exec) begin
      last_status_reg <= status;
    end else if (rx_err) begin
      last_status_reg <= pci_pkg::ST_CKSUM;
    end
  end

  // software control registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      standalone_reg <= 1'b0;
      point_idx_reg  <= 5'h00;
    end else if (reg_wr) begin
      if (reg_addr == pci_pkg::REG_CTRL) begin
        standalone_reg <= reg_wdata[pci_pkg::CTRL_STANDALONE_BIT];
      end
      if (reg_addr == pci_pkg::REG_POINT_IDX) begin
        point_idx_reg <= reg_wdata[4:0];
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere and when unmapped
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        pci_pkg::REG_CTRL:      reg_rdata <= {31'h0, standalone_reg};
        pci_pkg::REG_ACCU:      reg_rdata <= accu_reg;
        pci_pkg::REG_STAT:      reg_rdata <= {23'h0, exec, last_status_reg};
        pci_pkg::REG_POINT_IDX: reg_rdata <= {27'h0, point_idx_reg};
        default:                reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  move_ok_a: assert property (@(posedge mclk) disable iff (!reset_n)
    move_start |-> reply_valid && reply.status == pci_pkg::ST_OK && reply.value == 32'h0)
    else $error("move without ok reply");

  offset_move_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_move && f_reg.ptype == pci_pkg::RELATIVE_MOVE_TYPE
    |=> move_target == $past(act_pos) + $past(f_reg.value))
    else $error("relative target wrong");

  target_move_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_move && f_reg.ptype == pci_pkg::ABSOLUTE_MOVE_TYPE
    |=> move_start && move_target == $past(f_reg.value))
    else $error("absolute target wrong");

  act_pos_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_axr && f_reg.ptype == pci_pkg::AXIS_ACT_POS |=> reply.value == $past(act_pos))
    else $error("actual position not returned");

  accu_mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    accu_reg != $past(accu_reg) |-> $past(standalone_reg) && $past(is_axr || is_glr))
    else $error("accumulator changed in direct mode");

  nv_bank0_a: assert property (@(posedge mclk) disable iff (!reset_n)
    nv_save |-> $past(glob_wr) && nv_index[9:8] == 2'b00)
    else $error("save outside bank 0");

  bad_bank_a: assert property (@(posedge mclk) disable iff (!reset_n)
    exec && is_glw && !bank_ok |-> !glob_wr ##1 reply.status == pci_pkg::ST_BAD_VALUE)
    else $error("bad bank accepted");

  ser_addr_a: assert property (@(posedge mclk) disable iff (!reset_n)
    glob_wr && f_reg.bank == pci_pkg::BANK_MODULE && f_reg.ptype == pci_pkg::GLOB_SER_ADDR
    |=> ser_addr_reg == $past(f_reg.value[7:0]))
    else $error("serial address not updated");

  speed_a: assert property (@(posedge mclk) disable iff (!reset_n)
    axis_wr && f_reg.ptype == pci_pkg::AXIS_MAX_SPEED |=> max_speed == $past(f_reg.value))
    else $error("speed not taken");
endmodule

// File: hw/pci_pkg.sv
package pci_pkg;
  // frame layout and sizes
  localparam int          FRAME_BYTES    = 9;
  localparam logic [3:0]  LAST_BYTE_IDX  = 4'h8;
  // instruction numbers
  localparam logic [7:0]  MOVE_TO_POSITION_CMD = 8'h04;
  localparam logic [7:0]  AXIS_PARAM_WRITE_CMD = 8'h05;
  localparam logic [7:0]  AXIS_PARAM_READ_CMD  = 8'h06;
  localparam logic [7:0]  GLOBAL_PARAM_WRITE_CMD = 8'h09;
  localparam logic [7:0]  GLOBAL_PARAM_READ_CMD  = 8'h0a;
  // move types
  localparam logic [7:0]  ABSOLUTE_MOVE_TYPE          = 8'h00;
  localparam logic [7:0]  RELATIVE_MOVE_TYPE          = 8'h01;
  localparam logic [7:0]  STORED_COORDINATE_MOVE_TYPE = 8'h02;
  localparam logic [31:0] MAX_POINT_NUM  = 32'h0000_0014;
  // global parameter banks
  localparam logic [7:0]  BANK_MODULE    = 8'h00;
  localparam logic [7:0]  BANK_USER      = 8'h02;
  localparam logic [7:0]  BANK_IRQ_CFG   = 8'h03;
  // parameter numbers
  localparam logic [7:0]  AXIS_ACT_POS   = 8'h01;
  localparam logic [7:0]  AXIS_MAX_SPEED = 8'h04;
  localparam logic [7:0]  GLOB_SER_ADDR  = 8'h42;
  // reply status codes
  localparam logic [7:0]  ST_OK          = 8'h64;
  localparam logic [7:0]  ST_CKSUM       = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
  localparam logic [7:0]  ST_BAD_TYPE    = 8'h03;
  localparam logic [7:0]  ST_BAD_VALUE   = 8'h04;
  // reset values
  localparam logic [7:0]  SER_ADDR_RST   = 8'h01;
  localparam logic [31:0] MAX_SPEED_RST  = 32'h0000_0000;
  // register offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_ACCU       = 8'h04;
  localparam logic [7:0]  REG_STAT       = 8'h08;
  localparam logic [7:0]  REG_POINT_IDX  = 8'h0c;
  localparam logic [7:0]  REG_POINT_DATA = 8'h10;
  localparam int          CTRL_STANDALONE_BIT = 0;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  ptype;
    logic [7:0]  bank;
    logic [31:0] value;
  } pci_frame_type;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } pci_reply_type;

  typedef enum logic {PCI_IDLE, PCI_EXEC} pci_state_type;
endpackage

// File: hw/pci_mem.sv
`timescale 1ns/1ns
// simple dual port store, one write port, registered read port
module pci_mem #(
  parameter int W  = 32,
  parameter int D  = 256,
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [D];

  // contents are not reset: software or commands define them before use
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data always comes from a register, one cycle after the address
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// File: hw/pci_frame_rx.sv
`timescale 1ns/1ns
// assembles nine byte frames and checks address and checksum
module pci_frame_rx (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   rx_valid,
  input  wire logic                   rx_sof,
  input  wire logic [7:0]             rx_byte,
  input  wire logic [7:0]             own_addr,
  output pci_pkg::pci_frame_type      frame,
  output logic                        frame_valid,
  output logic                        cksum_err
);
  logic [3:0] cnt_reg;
  logic [7:0] sum_reg;
  logic [63:0] bytes_reg;
  logic       last;
  logic       mine;

  // a start marker always restarts the frame, so a broken frame cannot stick
  assign last = rx_valid && !rx_sof && (cnt_reg == pci_pkg::LAST_BYTE_IDX);
  assign mine = (bytes_reg[63:56] == own_addr);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_reg <= 4'h0;
    end else if (rx_valid) begin
      cnt_reg <= rx_sof ? 4'h1 : (last ? 4'h0 : cnt_reg + 4'h1);
    end
  end

  // bytes shift in first byte first, so the value lands msb first
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bytes_reg <= 64'h0;
      sum_reg   <= 8'h00;
    end else if (rx_valid && !last) begin
      bytes_reg <= rx_sof ? {56'h0, rx_byte} : {bytes_reg[55:0], rx_byte};
      sum_reg   <= rx_sof ? rx_byte : sum_reg + rx_byte;
    end
  end

  // frame only released when the checksum matches
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      frame       <= '0;
      frame_valid <= 1'b0;
      cksum_err   <= 1'b0;
    end else begin
      frame_valid <= last && mine && (sum_reg == rx_byte);
      cksum_err   <= last && mine && (sum_reg != rx_byte);
      if (last) begin
        frame <= bytes_reg;
      end
    end
  end

  chk_sum_a: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_valid |-> $past(sum_reg) == $past(rx_byte))
    else $error("frame released with bad checksum");
endmodule

// File: test/pci_host_model.sv
`timescale 1ns/1ns
// host side of the frame link: whole nine byte frames, one byte per clock
module pci_host_model (
  input  wire logic       mclk,
  output logic            rx_valid,
  output logic            rx_sof,
  output logic [7:0]      rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_sof   = 1'b0;
    rx_byte  = 8'h00;
  end

  // bad_ck spoils the checksum on purpose so that the frame must be refused
  task automatic send(input logic [7:0] addr, input logic [7:0] instr, input logic [7:0] ptype,
                      input logic [7:0] bank, input logic [31:0] value, input logic bad_ck);
    logic [7:0] b [9];
    b = '{addr, instr, ptype, bank, value[31:24], value[23:16], value[15:8], value[7:0],
          8'h00};
    for (int i = 0; i < 8; i++) begin
      b[8] = b[8] + b[i];
    end
    if (bad_ck) begin
      b[8] = b[8] ^ 8'h5a;
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_sof   <= (i == 0);
      rx_byte  <= b[i];
    end
    // idle byte flips so a stale checksum byte is never mistaken for data
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_sof   <= 1'b0;
    rx_byte  <= ~b[8];
  endtask
endmodule

// File: test/pci_interp_tb.sv
`timescale 1ns/1ns
module pci_interp_tb;
  logic                   mclk, reset_n, rx_valid, rx_sof, reply_valid, move_start;
  logic                   nv_save, reg_wr, reg_rd, got, ms, nv;
  logic [7:0]             rx_byte, reg_addr;
  logic [9:0]             nv_index, nvi;
  logic [31:0]            act_pos, move_target, max_speed, nv_value, reg_wdata, reg_rdata;
  logic [31:0]            rd, nvv;
  pci_pkg::pci_reply_type reply, rep;
  logic [7:0]             banks [3] = '{8'h00, 8'h02, 8'h03};
  int                     errors, check_count, cycles, lat;
  // short names keep every scenario line under the width limit
  localparam logic [7:0]  C_MOVE   = pci_pkg::MOVE_TO_POSITION_CMD;
  localparam logic [7:0]  C_AXW    = pci_pkg::AXIS_PARAM_WRITE_CMD;
  localparam logic [7:0]  C_AXR    = pci_pkg::AXIS_PARAM_READ_CMD;
  localparam logic [7:0]  C_GLW    = pci_pkg::GLOBAL_PARAM_WRITE_CMD;
  localparam logic [7:0]  C_GLR    = pci_pkg::GLOBAL_PARAM_READ_CMD;
  localparam logic [7:0]  T_TARGET = pci_pkg::ABSOLUTE_MOVE_TYPE;
  localparam logic [7:0]  T_OFFSET = pci_pkg::RELATIVE_MOVE_TYPE;
  localparam logic [7:0]  T_STORED = pci_pkg::STORED_COORDINATE_MOVE_TYPE;

  pci_host_model host (.mclk(mclk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_byte(rx_byte));

  pci_interp dut (
    .mclk(mclk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_byte(rx_byte),
    .reply_valid(reply_valid), .reply(reply), .act_pos(act_pos), .move_start(move_start),
    .move_target(move_target), .max_speed(max_speed), .nv_save(nv_save),
    .nv_index(nv_index), .nv_value(nv_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // the run needs well under a thousand cycles; a hang ends here
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] g, input logic [31:0] e, input string what);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string what);
    check_val({24'h0, g}, {24'h0, e}, what);
  endtask

  task automatic check_flag(input logic g, input logic e, input string what);
    check_val({31'h0, g}, {31'h0, e}, what);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rd = reg_rdata;
  endtask

  // one frame, then collect reply and the one-cycle pulses beside it
  task automatic xfer(input logic [7:0] a, input logic [7:0] i, input logic [7:0] t,
                      input logic [7:0] b, input logic [31:0] v, input logic bad);
    got = 1'b0;
    ms  = 1'b0;
    nv  = 1'b0;
    lat = 0;
    host.send(a, i, t, b, v, bad);
    while (!got && lat < 8) begin
      @(negedge mclk);
      lat++;
      if (move_start === 1'b1) ms = 1'b1;
      if (nv_save === 1'b1) begin
        nv  = 1'b1;
        nvi = nv_index;
        nvv = nv_value;
      end
      if (reply_valid === 1'b1) begin
        got = 1'b1;
        rep = reply;
      end
    end
  endtask

  initial begin
    reset_n   = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    act_pos   = 32'h0000_1388;
    errors    = 0;
    check_count = 0;
    cycles    = 0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    reg_read(pci_pkg::REG_CTRL);
    check_val(rd, 32'h0, "ctrl after reset");
    check_val(max_speed, pci_pkg::MAX_SPEED_RST, "speed after reset");
    reg_read(8'h20);
    check_val(rd, 32'h0, "unmapped read");
    // speed write stays volatile
    xfer(8'h01, C_AXW, pci_pkg::AXIS_MAX_SPEED, 8'h00, 32'h0000_c800, 1'b0);
    check_byte(rep.status, pci_pkg::ST_OK, "axis write status");
    check_byte(rep.instr, C_AXW, "reply instruction");
    check_byte(8'(lat), 8'h03, "reply latency");
    check_flag(nv, 1'b0, "axis write persisted");
    check_val(max_speed, 32'h0000_c800, "max speed");
    // direct mode read leaves the accumulator alone
    xfer(8'h01, C_AXR, pci_pkg::AXIS_MAX_SPEED, 8'h00, 32'h0, 1'b0);
    check_val(rep.value, 32'h0000_c800, "axis read");
    reg_read(pci_pkg::REG_ACCU);
    check_val(rd, 32'h0, "accu in direct mode");
    reg_write(pci_pkg::REG_CTRL, 32'h1);
    act_pos <= 32'h0001_2345;
    xfer(8'h01, C_AXR, pci_pkg::AXIS_ACT_POS, 8'h00, 32'h0, 1'b0);
    check_val(rep.value, 32'h0001_2345, "actual position");
    reg_read(pci_pkg::REG_ACCU);
    check_val(rd, 32'h0001_2345, "accu in standalone");
    reg_write(pci_pkg::REG_CTRL, 32'h0);
    // backward offset of 10000 from 5000
    act_pos <= 32'h0000_1388;
    xfer(8'h01, C_MOVE, T_OFFSET, 8'h00, 32'hffff_d8f0, 1'b0);
    check_flag(ms, 1'b1, "relative start");
    check_val(move_target, 32'hffff_ec78, "relative target");
    xfer(8'h01, C_MOVE, T_TARGET, 8'h00, 32'h7fff_ffff, 1'b0);
    check_val(move_target, 32'h7fff_ffff, "absolute target");
    reg_write(pci_pkg::REG_POINT_IDX, 32'h8);
    reg_write(pci_pkg::REG_POINT_DATA, 32'h0001_5f90);
    reg_read(pci_pkg::REG_POINT_IDX);
    check_val(rd, 32'h8, "coordinate index");
    xfer(8'h01, C_MOVE, T_STORED, 8'h00, 32'h8, 1'b0);
    check_flag(ms, 1'b1, "coordinate start");
    check_val(move_target, 32'h0001_5f90, "coordinate target");
    xfer(8'h01, C_MOVE, T_STORED, 8'h00, 32'h15, 1'b0);
    check_byte(rep.status, pci_pkg::ST_BAD_VALUE, "coordinate range");
    check_flag(ms, 1'b0, "out of range move");
    xfer(8'h01, C_MOVE, 8'h03, 8'h00, 32'h0, 1'b0);
    check_byte(rep.status, pci_pkg::ST_BAD_TYPE, "move type 3");
    xfer(8'h01, 8'h30, 8'h00, 8'h00, 32'h0, 1'b0);
    check_byte(rep.status, pci_pkg::ST_BAD_CMD, "unknown instruction");
    // spoiled checksum: nothing moves
    xfer(8'h01, C_MOVE, T_TARGET, 8'h00, 32'h10, 1'b1);
    check_byte(rep.status, pci_pkg::ST_CKSUM, "checksum status");
    check_byte(rep.instr, C_MOVE, "refused instruction");
    check_flag(ms, 1'b0, "bad frame moved");
    // same number in three banks: all written before any read back
    for (int k = 0; k < 3; k++) begin
      xfer(8'h01, C_GLW, 8'h07, banks[k], 32'ha5a5_0000 + k, 1'b0);
      check_byte(rep.status, pci_pkg::ST_OK, "global write");
      check_flag(nv, k == 0, "bank save pulse");
    end
    check_val({22'h0, nvi}, 32'h007, "save index");
    check_val(nvv, 32'ha5a5_0000, "save value");
    for (int k = 0; k < 3; k++) begin
      xfer(8'h01, C_GLR, 8'h07, banks[k], 32'hdead_beef, 1'b0);
      check_val(rep.value, 32'ha5a5_0000 + k, "global read");
    end
    xfer(8'h01, C_GLW, 8'h07, 8'h01, 32'h0, 1'b0);
    check_byte(rep.status, pci_pkg::ST_BAD_VALUE, "bank 1");
    reg_read(pci_pkg::REG_STAT);
    check_val(rd, {24'h0, pci_pkg::ST_BAD_VALUE}, "last status");
    // new serial address: old one goes deaf, new one answers
    xfer(8'h01, C_GLW, pci_pkg::GLOB_SER_ADDR, 8'h00, 32'h3, 1'b0);
    check_val({22'h0, nvi}, 32'h042, "address save index");
    xfer(8'h01, C_GLR, pci_pkg::GLOB_SER_ADDR, 8'h00, 32'h0, 1'b0);
    check_flag(got, 1'b0, "old address answered");
    xfer(8'h03, C_GLR, pci_pkg::GLOB_SER_ADDR, 8'h00, 32'h0, 1'b0);
    check_val(rep.value, 32'h3, "serial address");
    // mid-run reset: address and accumulator fall back to their reset values
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    reg_read(pci_pkg::REG_ACCU);
    check_val(rd, 32'h0, "accu after reset");
    xfer(pci_pkg::SER_ADDR_RST, C_GLR, pci_pkg::GLOB_SER_ADDR, 8'h00, 32'h0, 1'b0);
    check_val(rep.value, {24'h0, pci_pkg::SER_ADDR_RST}, "address after reset");
    stop_test;
  end
endmodule
